// >>> src/pin_filter.sv
// Synchroniser and low-level glitch filter for the reset pin
`timescale 1ns/1ns
module pin_filter (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Pin and result
  input wire logic pin_in,
  output logic low_q
);
  logic s1_q, s1_d, s2_q, s2_d, low_d;
  logic [rst_cfg_pkg::FILT_W-1:0] cnt_q, cnt_d;

  // Count consecutive low samples after two-stage sync
  always_comb begin
    s1_d = pin_in;
    s2_d = s1_q;
    cnt_d = cnt_q;
    low_d = low_q;
    if (s2_q) begin
      cnt_d = '0;
      low_d = 1'b0;
    end else if (cnt_q == rst_cfg_pkg::FILT_LAST) begin
      low_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  // Registers, pin idles high
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      cnt_q <= '0;
      low_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
    end
  end
endmodule

// >>> src/rst_cfg_pkg.sv
// Constants for the reset pin and configuration word two decoder
package rst_cfg_pkg;
  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam int CFG_W = 14;
  localparam int BIT_LVP = 13;
  localparam int BIT_DBG = 12;
  localparam int BIT_BOR = 10;
  localparam int BIT_STK = 9;
  localparam int BIT_PLL = 8;
  localparam int BIT_RSV = 4;
  localparam int BIT_WP_HI = 1;
  localparam logic [13:0] CFG_BLANK = 14'h3FFF;
  localparam logic [13:0] CFG_FIXED_ONES = 14'h08EC;
  localparam logic [13:0] CFG_PROG_MASK = 14'h3713;
  // ----------------------------------------------------------------
  // Self-write protection limits (last protected address)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam logic [12:0] WP_LIM_SMALL = 13'h01FF;
  localparam logic [12:0] WP_LIM_HALF = 13'h0FFF;
  localparam logic [12:0] WP_LIM_ALL = 13'h1FFF;
  // ----------------------------------------------------------------
  // Reset pin glitch filter
  // ----------------------------------------------------------------
  localparam int FILT_NS = 100;
  localparam int CLK_NS = 10;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_W = 4;
  localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);
endpackage

// >>> src/rst_cfg_top.sv
// Reset pin control and configuration word two decoding
`timescale 1ns/1ns
module rst_cfg_top (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Programming interface
  input wire logic prog_mode,
  input wire logic prog_via_lv,
  input wire logic prog_write,
  input wire logic prog_erase,
  input wire logic [13:0] prog_data,
  input wire logic reset_pin_enable,
  // External reset pin, input only
  input wire logic external_reset_pin,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pullup_q,
  input wire logic sw_pullup,
  output logic gpio_in_q,
  // Startup and stack faults
  input wire logic timers_done,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic flag_clear,
  // Decoded outputs
  output logic [13:0] config_word_two,
  output logic hold_reset_q,
  output logic run_q,
  output logic debugger_pins_q,
  output logic lv_entry_ok_q,
  output logic bor_low_trip_q,
  output logic stack_reset_q,
  output logic clock_multiplier_enable,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag,
  // Flash write check
  input wire logic [12:0] wr_addr,
  output logic wr_blocked_q
);
  logic [13:0] cfg_q, cfg_d;
  logic pin_low;
  logic rpe_on;
  logic hold_d, run_d, pull_d, gpio_d, dbg_d, lve_d, bor_d, stk_d, pll_d;
  logic ovf_q, ovf_d, unf_q, unf_d, blk_d;
  logic [12:0] lim;
  logic [1:0] wp;
  logic [3:0] low_run_q, low_run_d;

  // ----------------------------------------------------------------
  // Reset pin path
  // ----------------------------------------------------------------
  pin_filter u_filt (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(external_reset_pin),
    .low_q(pin_low)
  );

  assign pin_out = 1'b0;
  assign pin_oe = 1'b0;

  // Configuration word storage and programming
  always_comb begin
    cfg_d = cfg_q;
    if (prog_mode && prog_erase) begin
      cfg_d = rst_cfg_pkg::CFG_BLANK;
    end else if (prog_mode && prog_write) begin
      cfg_d = (prog_data & rst_cfg_pkg::CFG_PROG_MASK)
              | rst_cfg_pkg::CFG_FIXED_ONES;
      // keep bit at its old value in low-voltage mode
      if (prog_via_lv) begin
        cfg_d[rst_cfg_pkg::BIT_LVP] = cfg_q[rst_cfg_pkg::BIT_LVP];
      end
    end
  end

  // Decoding
  always_comb begin
    rpe_on = cfg_q[rst_cfg_pkg::BIT_LVP] | reset_pin_enable;
    hold_d = rpe_on & pin_low;
    run_d = timers_done & ~hold_d;
    pull_d = rpe_on | sw_pullup;
    gpio_d = rpe_on ? 1'b0 : external_reset_pin;
    dbg_d = ~cfg_q[rst_cfg_pkg::BIT_DBG];
    lve_d = cfg_q[rst_cfg_pkg::BIT_LVP];
    bor_d = cfg_q[rst_cfg_pkg::BIT_BOR];
    stk_d = cfg_q[rst_cfg_pkg::BIT_STK] & (stack_overflow | stack_underflow);
    pll_d = cfg_q[rst_cfg_pkg::BIT_PLL];
    ovf_d = (ovf_q & ~flag_clear) | (stk_d & stack_overflow);
    unf_d = (unf_q & ~flag_clear) | (stk_d & stack_underflow);
    wp = cfg_q[rst_cfg_pkg::BIT_WP_HI:0];
    case (wp)
      2'h2: lim = rst_cfg_pkg::WP_LIM_SMALL;
      2'h1: lim = rst_cfg_pkg::WP_LIM_HALF;
      default: lim = rst_cfg_pkg::WP_LIM_ALL;
    endcase
    blk_d = (wp != 2'h3) && (wr_addr <= lim);
  end

  // Registers
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q <= rst_cfg_pkg::CFG_BLANK;
      hold_reset_q <= 1'b0;
      run_q <= 1'b0;
      pin_pullup_q <= 1'b1;
      gpio_in_q <= 1'b0;
      debugger_pins_q <= 1'b0;
      lv_entry_ok_q <= 1'b1;
      bor_low_trip_q <= 1'b1;
      stack_reset_q <= 1'b0;
      clock_multiplier_enable <= 1'b1;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      wr_blocked_q <= 1'b0;
    end else if (clk_en) begin
      cfg_q <= cfg_d;
      hold_reset_q <= hold_d;
      run_q <= run_d;
      pin_pullup_q <= pull_d;
      gpio_in_q <= gpio_d;
      debugger_pins_q <= dbg_d;
      lv_entry_ok_q <= lve_d;
      bor_low_trip_q <= bor_d;
      stack_reset_q <= stk_d;
      clock_multiplier_enable <= pll_d;
      ovf_q <= ovf_d;
      unf_q <= unf_d;
      wr_blocked_q <= blk_d;
    end
  end

  // Read value straight from the register, fixed ones already held
  assign config_word_two = cfg_q;
  assign stack_overflow_flag = ovf_q;
  assign stack_underflow_flag = unf_q;

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------

  // Consecutive low samples of the raw pin, saturating
  always_comb begin
    low_run_d = low_run_q;
    if (external_reset_pin) begin
      low_run_d = '0;
    end else if (low_run_q != 4'hF) begin
      low_run_d = low_run_q + 4'h1;
    end
  end

  // Helper register, frozen with the rest of the block
  always_ff @(posedge clock) begin
    if (rst) begin
      low_run_q <= '0;
    end else if (clk_en) begin
      low_run_q <= low_run_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pin_never_driven: assert property (
    @(posedge clock) !pin_oe) else $error("reset pin driven");
  a_hold_follows_pin: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && rpe_on && pin_low |=> hold_reset_q)
    else $error("pin low not holding reset");
  a_no_hold_disabled: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && !rpe_on |=> !hold_reset_q)
    else $error("hold while disabled");
  a_pullup_forced: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && rpe_on |=> pin_pullup_q) else $error("pull-up off");
  a_pullup_software: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && !rpe_on |=> pin_pullup_q == $past(sw_pullup))
    else $error("pull-up not software");
  a_fixed_ones_read: assert property (
    @(posedge clock) disable iff (rst)
    (config_word_two & rst_cfg_pkg::CFG_FIXED_ONES)
    == rst_cfg_pkg::CFG_FIXED_ONES) else $error("unimpl bit zero");
  a_lvp_kept: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && prog_mode && prog_write && !prog_erase && prog_via_lv
    |=> $stable(cfg_q[13])) else $error("lvp changed in lv mode");
  a_no_run_held: assert property (
    @(posedge clock) disable iff (rst)
    hold_reset_q |-> !run_q) else $error("run while held");
  a_ovf_flag_set: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && cfg_q[9] && stack_overflow |=> stack_overflow_flag)
    else $error("overflow flag missed");
  a_glitch_ignored: assert property (
    @(posedge clock) disable iff (rst)
    $rose(pin_low) && $past(clk_en, 2)
    |-> $past(low_run_q, 2) >= 4'(rst_cfg_pkg::FILT_CYC))
    else $error("short low pulse reached the filter output");
  a_long_low_holds: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && low_run_q == 4'(rst_cfg_pkg::FILT_CYC + 1) |=> pin_low)
    else $error("long low pulse not passed by the filter");
  a_gpio_reads_pin: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && !rpe_on |=> gpio_in_q == $past(external_reset_pin))
    else $error("input not following pin");
  a_run_needs_timers: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && !timers_done |=> !run_q) else $error("run before timers");
  a_write_refused: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && !prog_mode |=> $stable(cfg_q)) else $error("word changed");
  a_stack_gate: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && !cfg_q[rst_cfg_pkg::BIT_STK] |=> !stack_reset_q)
    else $error("stack reset while gated off");
  a_unf_flag_set: assert property (
    @(posedge clock) disable iff (rst)
    clk_en && cfg_q[rst_cfg_pkg::BIT_STK] && stack_underflow
    |=> stack_underflow_flag) else $error("underflow flag missed");
endmodule

// >>> tb/reset_driver.sv
// Board-side driver that can pull the reset pin low
`timescale 1ns/1ns
module reset_driver (
  // Clock
  input wire logic clock,
  // Control and pin
  input wire logic drive_low,
  input wire logic pullup_on,
  output logic pin
);
  logic float_q = 1'h0;
  // Released pin without pull-up wanders every cycle
  always_ff @(posedge clock) begin
    float_q <= ~float_q;
  end
  // Pin level: driven low, pulled up or floating
  assign pin = drive_low ? 1'h0 : (pullup_on ? 1'h1 : float_q);
endmodule

// >>> tb/tb_reset_pin_config_decode.sv
// Self-checking bench for the reset pin and config word decoder
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb_reset_pin_config_decode;
  logic clock = 1'h0, rst = 1'h1, clk_en = 1'h1, prog_mode = 1'h0;
  logic prog_via_lv = 1'h0, prog_write = 1'h0, prog_erase = 1'h0;
  logic reset_pin_enable = 1'h1, sw_pullup = 1'h1, timers_done = 1'h1;
  logic stack_overflow = 1'h0, stack_underflow = 1'h0, flag_clear = 1'h0;
  logic drv_low = 1'h0, seen;
  logic [13:0] prog_data = 14'h0000;
  logic [12:0] wr_addr = 13'h0000;
  logic [13:0] config_word_two;
  logic external_reset_pin, pin_out, pin_oe, pin_pullup_q, gpio_in_q;
  logic hold_reset_q, run_q, debugger_pins_q, lv_entry_ok_q;
  logic bor_low_trip_q, stack_reset_q, clock_multiplier_enable;
  logic stack_overflow_flag, stack_underflow_flag, wr_blocked_q;
  int fails = 0, n_checks = 0;
  // Device and board
  rst_cfg_top dut (.clock, .rst, .clk_en, .prog_mode, .prog_via_lv,
    .prog_write, .prog_erase, .prog_data, .reset_pin_enable,
    .external_reset_pin, .pin_out, .pin_oe, .pin_pullup_q, .sw_pullup,
    .gpio_in_q, .timers_done, .stack_overflow, .stack_underflow,
    .flag_clear, .config_word_two, .hold_reset_q, .run_q,
    .debugger_pins_q, .lv_entry_ok_q, .bor_low_trip_q, .stack_reset_q,
    .clock_multiplier_enable, .stack_overflow_flag,
    .stack_underflow_flag, .wr_addr, .wr_blocked_q);
  reset_driver board (.clock, .drive_low(drv_low),
    .pullup_on(pin_pullup_q), .pin(external_reset_pin));
  // Clock
  always #5 clock = ~clock;
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task prog(input logic [13:0] d);
    @(posedge clock);
    prog_data <= d | 14'h0010;
    prog_write <= 1'h1;
    @(posedge clock) prog_write <= 1'h0;
    cyc(3);
  endtask
  task wait_hold(input logic v);
    for (int i = 0; i < 40 && hold_reset_q !== v; i++) cyc(1);
    `CHK(hold_reset_q, v)
    if (hold_reset_q !== v) report_and_stop();
  endtask
  task stack_evt(input logic ovf);
    @(posedge clock);
    stack_overflow <= ovf;
    stack_underflow <= ~ovf;
    @(posedge clock);
    stack_overflow <= 1'h0;
    stack_underflow <= 1'h0;
    // Reset pulse stands only until the next edge
    #1;
    seen = stack_reset_q;
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      seen = seen | stack_reset_q;
    end
  endtask
  task t_reset;
    `CHK(config_word_two, 14'h3FFF)
    `CHK({lv_entry_ok_q, bor_low_trip_q, clock_multiplier_enable}, 3'h7)
    `CHK({pin_out, pin_oe, pin_pullup_q}, 3'h1)
    $display("done reset");
  endtask
  task t_fields;
    prog(14'h2710);
    `CHK(config_word_two, 14'h3FFF)
    @(posedge clock) prog_mode <= 1'h1;
    prog(14'h1010);
    `CHK(config_word_two, 14'h18FC)
    `CHK({lv_entry_ok_q, debugger_pins_q, bor_low_trip_q}, 3'h0)
    `CHK(clock_multiplier_enable, 1'h0)
    prog(14'h2710);
    `CHK(config_word_two, 14'h2FFC)
    `CHK({lv_entry_ok_q, debugger_pins_q, bor_low_trip_q}, 3'h7)
    `CHK(clock_multiplier_enable, 1'h1)
    // erase returns debugger bit to 1
    @(posedge clock) prog_erase <= 1'h1;
    @(posedge clock) prog_erase <= 1'h0;
    cyc(3);
    `CHK(config_word_two, 14'h3FFF)
    $display("done fields");
  endtask
  task t_wrt;
    logic [12:0] a [4] = '{13'h01FF, 13'h0200, 13'h0FFF, 13'h1000};
    logic [12:0] lim [3] = '{13'h1FFF, 13'h0FFF, 13'h01FF};
    for (int w = 0; w < 4; w++) begin
      prog(14'h3FFC | 14'(w));
      for (int k = 0; k < 4; k++) begin
        @(posedge clock) wr_addr <= a[k];
        cyc(2);
        `CHK(wr_blocked_q, 1'(w != 3 && a[k] <= lim[w % 3]))
      end
    end
    $display("done write protect");
  endtask
  task t_lvp;
    @(posedge clock) prog_via_lv <= 1'h1;
    prog(14'h1FFF);
    `CHK({config_word_two[13], lv_entry_ok_q}, 2'h3)
    @(posedge clock) prog_via_lv <= 1'h0;
    $display("done lvp lock");
  endtask
  task t_pin;
    @(posedge clock) timers_done <= 1'h0;
    cyc(2);
    `CHK(run_q, 1'h0)
    @(posedge clock) begin
      timers_done <= 1'h1;
      reset_pin_enable <= 1'h0;
    end
    @(posedge clock) drv_low <= 1'h1;
    repeat (8) @(posedge clock);
    drv_low <= 1'h0;
    cyc(20);
    `CHK(hold_reset_q, 1'h0)
    @(posedge clock) drv_low <= 1'h1;
    wait_hold(1'h1);
    cyc(2);
    `CHK({run_q, pin_pullup_q, gpio_in_q, pin_oe}, 4'h4)
    @(posedge clock) drv_low <= 1'h0;
    wait_hold(1'h0);
    cyc(2);
    `CHK(run_q, 1'h1)
    $display("done pin");
  endtask
  task t_gpio;
    @(posedge clock) reset_pin_enable <= 1'h0;
    prog(14'h1FFF);
    @(posedge clock) drv_low <= 1'h1;
    cyc(20);
    `CHK({hold_reset_q, gpio_in_q, pin_pullup_q}, 3'h1)
    @(posedge clock) drv_low <= 1'h0;
    cyc(4);
    `CHK(gpio_in_q, 1'h1)
    @(posedge clock) sw_pullup <= 1'h0;
    cyc(3);
    `CHK(pin_pullup_q, 1'h0)
    @(posedge clock) reset_pin_enable <= 1'h1;
    cyc(3);
    `CHK(pin_pullup_q, 1'h1)
    $display("done gpio");
  endtask
  task t_stack;
    stack_evt(1'h1);
    `CHK({seen, stack_overflow_flag}, 2'h3)
    @(posedge clock) flag_clear <= 1'h1;
    @(posedge clock) flag_clear <= 1'h0;
    stack_evt(1'h0);
    `CHK({stack_overflow_flag, stack_underflow_flag}, 2'h1)
    prog(14'h1DFF);
    stack_evt(1'h1);
    `CHK({seen, stack_overflow_flag}, 2'h0)
    $display("done stack");
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    cyc(2);
    t_reset();
    t_fields();
    t_wrt();
    t_lvp();
    t_pin();
    t_gpio();
    t_stack();
    report_and_stop();
  end
endmodule
